// File: src/data_move_instruction_exec.sv
/*
 * decode and execute of the register move, memory-to-memory copy and bank load.
 * assumes program words come from same-clock fetch logic, and that the data memory
 * returns mem_rdata in the pclk cycle after mem_rd. one instruction cycle = 4 pclk.
 */
`include "move_exec_cfg.svh"

module data_move_instruction_exec (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// program words
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire logic skip_next,
	output logic instr_take,
	// indexed mode base
	input wire logic [11:0] index_base,
	// data memory
	output logic [11:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// core state
	output logic [7:0] wreg,
	output logic [7:0] bank_select_register,
	output logic flag_n,
	output logic flag_z
);

	////////////////////////////////////////////////////////////////////////////////
	// effective address of a register move
	function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a, input logic ext,
		input logic [7:0] bank, input logic [11:0] base);
		logic [11:0] r;
		r = {bank[3:0], f};
		if (!a) begin
			if (ext && f <= `INDEX_LIMIT) begin
				r = base + {`NIBBLE_ZERO, f};
			end else if (f < `ACCESS_SPLIT) begin
				r = {`NIBBLE_ZERO, f};
			end else begin
				r = {`ACCESS_HI, f};
			end
		end
		return r;
	endfunction : eff_addr

	////////////////////////////////////////////////////////////////////////////////
	// apb slave
	logic ext_r, ext_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;

	logic [1:0] ph_r, ph_nxt;
	logic [15:0] ir_r, ir_nxt;
	logic ir_vld_r, ir_vld_nxt;
	logic ir_skip_r, ir_skip_nxt;
	move_exec_pkg::seq_state_type seq_r, seq_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] w_r, w_nxt;
	logic [7:0] bank_r, bank_nxt;
	logic n_r, n_nxt;
	logic z_r, z_nxt;
	logic take_r, take_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic rd_r, rd_nxt;
	logic wr_r, wr_nxt;
	logic [7:0] wdata_r, wdata_nxt;

	always_comb begin
		ext_nxt = ext_r;
		pready_nxt = psel && !penable;
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			if (paddr == `REG_CTRL) begin
				prdata_nxt[`CTRL_EXT] = ext_r;
			end else if (paddr == `REG_STATE && !pwrite) begin
				prdata_nxt[`ST_W_LSB +: 8] = w_r;
				prdata_nxt[`ST_BANK_LSB +: 4] = bank_r[3:0];
				prdata_nxt[`ST_Z] = z_r;
				prdata_nxt[`ST_N] = n_r;
				prdata_nxt[`ST_BUSY] = seq_r != move_exec_pkg::st_run;
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		if (psel && penable && pready_r && pwrite && paddr == `REG_CTRL) begin
			ext_nxt = pwdata[`CTRL_EXT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ext_r <= ext_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode
	logic is_move, is_src, is_dst, is_bank, dst_word;
	logic [7:0] src_val;

	assign is_move = ir_r[15:10] == `OPC_MOVE;
	assign is_src = ir_r[15:12] == `OPC_COPY_SRC;
	assign is_dst = ir_r[15:12] == `OPC_COPY_DST;
	assign is_bank = ir_r[15:8] == `OPC_BANK;
	assign dst_word = is_dst && seq_r != move_exec_pkg::st_run;
	// W read in place of memory
	assign src_val = (addr_r == `W_ADDR) ? w_r : mem_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// execute
	always_comb begin
		ph_nxt = ph_r + 2'h1;
		ir_nxt = ir_r;
		ir_vld_nxt = ir_vld_r;
		ir_skip_nxt = ir_skip_r;
		seq_nxt = seq_r;
		data_nxt = data_r;
		w_nxt = w_r;
		bank_nxt = bank_r;
		n_nxt = n_r;
		z_nxt = z_r;
		take_nxt = 1'b0;
		addr_nxt = addr_r;
		rd_nxt = 1'b0;
		wr_nxt = 1'b0;
		wdata_nxt = wdata_r;
		unique case (ph_r)
			`PH_Q1: begin
				ir_vld_nxt = instr_valid;
				if (instr_valid) begin
					ir_nxt = instr_word;
					ir_skip_nxt = skip_next;
					take_nxt = 1'b1;
				end
			end
			`PH_Q2: begin
				if (ir_vld_r && !ir_skip_r && !dst_word) begin
					if (is_move) begin
						addr_nxt = eff_addr(ir_r[7:0], ir_r[`BIT_BANK], ext_r, bank_r, index_base);
						rd_nxt = eff_addr(ir_r[7:0], ir_r[`BIT_BANK], ext_r, bank_r, index_base) != `W_ADDR;
					end else if (is_src) begin
						addr_nxt = ir_r[11:0];
						rd_nxt = ir_r[11:0] != `W_ADDR;
					end else if (is_bank) begin
						bank_nxt = {`NIBBLE_ZERO, ir_r[3:0]};
					end
				end
			end
			`PH_Q3: begin
				rd_nxt = 1'b0;
			end
			`PH_Q4: begin
				if (ir_vld_r) begin
					seq_nxt = move_exec_pkg::st_run;
					if (dst_word) begin
						if (seq_r == move_exec_pkg::st_copy_dst) begin
							addr_nxt = ir_r[11:0];
							if (ir_r[11:0] == `W_ADDR) begin
								w_nxt = data_r;
							end else begin
								wdata_nxt = data_r;
								wr_nxt = 1'b1;
							end
						end
					end else if (is_src) begin
						seq_nxt = ir_skip_r ? move_exec_pkg::st_copy_skip : move_exec_pkg::st_copy_dst;
						data_nxt = src_val;
					end else if (is_move && !ir_skip_r) begin
						n_nxt = src_val[7];
						z_nxt = src_val == 8'h00;
						if (!ir_r[`BIT_DEST] || addr_r == `W_ADDR) begin
							w_nxt = src_val;
						end else begin
							wdata_nxt = src_val;
							wr_nxt = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r <= `PH_Q1;
			ir_r <= 16'h0000;
			ir_vld_r <= 1'b0;
			ir_skip_r <= 1'b0;
			seq_r <= move_exec_pkg::st_run;
			data_r <= 8'h00;
			w_r <= `W_RST;
			bank_r <= `BANK_RST;
			n_r <= 1'b0;
			z_r <= 1'b0;
			take_r <= 1'b0;
			addr_r <= 12'h000;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			wdata_r <= 8'h00;
		end else begin
			ph_r <= ph_nxt;
			ir_r <= ir_nxt;
			ir_vld_r <= ir_vld_nxt;
			ir_skip_r <= ir_skip_nxt;
			seq_r <= seq_nxt;
			data_r <= data_nxt;
			w_r <= w_nxt;
			bank_r <= bank_nxt;
			n_r <= n_nxt;
			z_r <= z_nxt;
			take_r <= take_nxt;
			addr_r <= addr_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign instr_take = take_r;
	assign mem_addr = addr_r;
	assign mem_rd = rd_r;
	assign mem_wr = wr_r;
	assign mem_wdata = wdata_r;
	assign wreg = w_r;
	assign bank_select_register = bank_r;
	assign flag_n = n_r;
	assign flag_z = z_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence move_issue;
		ph_r == `PH_Q2 && ir_vld_r && !ir_skip_r && !dst_word && is_move;
	endsequence
	sequence move_done;
		ph_r == `PH_Q4 && ir_vld_r && !ir_skip_r && !dst_word && is_move;
	endsequence
	sequence copy_src_issue;
		ph_r == `PH_Q2 && ir_vld_r && !ir_skip_r && !dst_word && is_src && ir_r[11:0] != `W_ADDR;
	endsequence
	sequence bank_issue;
		ph_r == `PH_Q2 && ir_vld_r && !ir_skip_r && !dst_word && is_bank;
	endsequence
	sequence copy_dst_done;
		ph_r == `PH_Q4 && ir_vld_r && dst_word && seq_r == move_exec_pkg::st_copy_dst;
	endsequence

	a_bank_high_zero: assert property (bank_r[7:4] == `NIBBLE_ZERO) else $error("bank upper nibble set");
	a_bank_load_val: assert property (bank_issue |=> bank_r[3:0] == $past(ir_r[3:0]) && $stable(n_r) && $stable(z_r))
		else $error("bank load wrong or flags moved");
	a_move_bank_addr: assert property (move_issue and ir_r[`BIT_BANK] |=> mem_addr == {bank_r[3:0], $past(ir_r[7:0])})
		else $error("banked move address wrong");
	a_move_index_addr: assert property (move_issue and !ir_r[`BIT_BANK] && ext_r && ir_r[7:0] <= `INDEX_LIMIT
		|=> mem_addr == $past(index_base) + {`NIBBLE_ZERO, $past(ir_r[7:0])}) else $error("indexed address wrong");
	a_move_to_w: assert property (move_done and !ir_r[`BIT_DEST] |=> wreg == $past(src_val) && !mem_wr)
		else $error("move to W failed");
	a_move_back: assert property (move_done and ir_r[`BIT_DEST] && addr_r != `W_ADDR
		|=> mem_wr && mem_wdata == $past(mem_rdata) && mem_addr == $past(mem_addr)) else $error("write back failed");
	a_move_flags: assert property (move_done |=> flag_z == ($past(src_val) == 8'h00) && flag_n == $past(src_val[7]))
		else $error("move flags wrong");
	a_copy_src_read: assert property (copy_src_issue |=> mem_rd && mem_addr == $past(ir_r[11:0]) ##1 !mem_rd ##1 !mem_rd)
		else $error("copy source read wrong");
	a_copy_no_read: assert property (seq_r == move_exec_pkg::st_copy_dst && is_dst |-> !mem_rd)
		else $error("dummy read in copy");
	a_copy_dst_write: assert property (copy_dst_done and ir_r[11:0] != `W_ADDR |=> mem_wr
		&& mem_addr == $past(ir_r[11:0]) && mem_wdata == $past(data_r)) else $error("copy write wrong");

endmodule : data_move_instruction_exec

// File: src/move_exec_cfg.svh
/*
 * constants for the data-move execute block: opcodes, address map, phases, apb map.
 * assumes a 12-bit data space and a 4-phase instruction cycle on pclk.
 */
`ifndef MOVE_EXEC_CFG_SVH
`define MOVE_EXEC_CFG_SVH

// opcodes
`define OPC_MOVE 6'h14
`define OPC_COPY_SRC 4'hC
`define OPC_COPY_DST 4'hF
`define OPC_BANK 8'h01

// data space
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI 4'hF
`define INDEX_LIMIT 8'h5F
`define W_ADDR 12'hF00
`define W_RST 8'h00
`define BANK_RST 8'h00
`define NIBBLE_ZERO 4'h0

// instruction bits
`define BIT_DEST 9
`define BIT_BANK 8

// phases of one instruction cycle
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

// apb map
`define REG_CTRL 12'h000
`define REG_STATE 12'h004
`define CTRL_EXT 0
`define ST_W_LSB 0
`define ST_BANK_LSB 8
`define ST_Z 12
`define ST_N 13
`define ST_BUSY 14

`endif

// File: src/move_exec_pkg.sv
/*
 * types of the data-move execute block.
 * assumes nothing beyond a systemverilog tool.
 */
package move_exec_pkg;
	typedef enum logic [1:0] {st_run, st_copy_dst, st_copy_skip} seq_state_type;
endpackage : move_exec_pkg

// File: tb/data_memory_model.sv
/* data memory behind the execute block: 4096 bytes, read data one cycle late.
   assumes mem_rd and mem_wr are one-cycle pulses on pclk. */
module data_memory_model (
	// clock
	input wire logic pclk,
	// access
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	// last written address
	output logic [11:0] waddr_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] m [4096];
	initial begin
		mem_rdata = 8'h00;
		waddr_seen = 12'h000;
		for (int i = 0; i < 4096; i++) m[i] = i[7:0] ^ 8'hA5;
	end
	always @(posedge pclk) begin
		if (mem_wr) begin
			m[mem_addr] <= mem_wdata;
			waddr_seen <= mem_addr;
		end
		// data only in the cycle after the strobe, toggling otherwise
		if (mem_rd) mem_rdata <= m[mem_addr];
		else mem_rdata <= ~mem_rdata;
	end
endmodule : data_memory_model

// File: tb/data_move_instruction_exec_test.sv
/* bench for the data-move execute block: apb, instruction stream, memory model.
   assumes a 4-pclk instruction cycle starting at reset release. */
`include "move_exec_cfg.svh"
module data_move_instruction_exec_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, skip_next = 0;
	logic [11:0] paddr = 0, index_base = 0, mem_addr, waddr_seen, adr, s, dt, bs;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] instr_word = 0;
	logic pready, pslverr, instr_take, mem_rd, mem_wr, flag_n, flag_z, err, n_e, z_e, d, a, skp, ext;
	logic [7:0] mem_wdata, mem_rdata, wreg, bank_select_register, w_e, v, f, k, old;
	int failures = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	data_move_instruction_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid), .skip_next(skip_next),
		.instr_take(instr_take), .index_base(index_base), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wreg(wreg),
		.bank_select_register(bank_select_register), .flag_n(flag_n), .flag_z(flag_z));
	data_memory_model mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .waddr_seen(waddr_seen));
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task end_sim;
		if (failures == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
		chk("pready idle", 0, pready);
	endtask : apb
	task run(input logic [15:0] wd, input logic sk);
		instr_word <= wd;
		instr_valid <= 1;
		skip_next <= sk;
		do @(posedge pclk);
		while (instr_take !== 1'h1);
	endtask : run
	task settle;
		instr_valid <= 0;
		repeat (8) @(posedge pclk);
	endtask : settle
	function automatic logic [11:0] ea(input logic a, input logic [7:0] f, input logic x, input logic [3:0] b,
		input logic [11:0] bb);
		if (a) return {b, f};
		if (x && f <= `INDEX_LIMIT) return bb + {4'h0, f};
		return (f < `ACCESS_SPLIT) ? {4'h0, f} : {`ACCESS_HI, f};
	endfunction : ea
	function automatic logic [7:0] rv(input logic [11:0] ad);
		return ad == `W_ADDR ? w_e : mem.m[ad];
	endfunction : rv
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++;
		end_sim;
	end
	initial begin
		void'($urandom(48));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `REG_CTRL, 0);
		chk("ctrl reset", 0, rd);
		apb(1, `REG_STATE, 32'hFF);
		chk("read-only error", 1, err);
		apb(0, 12'h008, 0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		{w_e, n_e, z_e} = 0;
		for (int i = 0; i < 24; i++) begin
			ext = i >= 12;
			apb(1, `REG_CTRL, {31'h0, ext});
			if (i == 7) run({`OPC_COPY_SRC, 12'h123}, 0);
			k = 8'($urandom);
			run({`OPC_BANK, k}, 0);
			settle;
			chk("bank", {4'h0, k[3:0]}, bank_select_register);
			chk("flag n kept", n_e, flag_n);
			chk("flag z kept", z_e, flag_z);
			{d, a, f} = 10'($urandom);
			if (i % 12 < 3) a = 0;
			if (i % 12 < 2) f = 8'(`INDEX_LIMIT + i % 12);
			if (i % 12 == 2) f = `ACCESS_SPLIT;
			bs = 12'($urandom);
			index_base <= bs;
			adr = ea(a, f, ext, k[3:0], bs);
			if (i % 12 == 3 && adr != `W_ADDR) mem.m[adr] = 0;
			v = rv(adr);
			mem.waddr_seen = ~adr;
			run({`OPC_MOVE, d, a, f}, 0);
			settle;
			if (!d) w_e = v;
			n_e = v[7];
			z_e = v == 0;
			chk("wreg", w_e, wreg);
			chk("flag n", n_e, flag_n);
			chk("flag z", z_e, flag_z);
			if (d && adr != `W_ADDR) chk("write back", adr, waddr_seen);
			s = 12'($urandom);
			// keep clear of counter and stack bytes
			dt = 12'($urandom % `W_ADDR);
			if (i == 3) s = `W_ADDR;
			if (i == 4) dt = `W_ADDR;
			if (i == 5) {s, dt} = {12'hFFF, 12'h000};
			skp = i == 6;
			v = rv(s);
			old = rv(dt);
			run({`OPC_COPY_SRC, s}, skp);
			run({`OPC_COPY_DST, dt}, 0);
			settle;
			if (!skp && dt == `W_ADDR) w_e = v;
			chk("copy", skp ? old : v, dt == `W_ADDR ? wreg : mem.m[dt]);
			if (i == 8) begin
				run({`OPC_COPY_DST, `W_ADDR}, 0);
				settle;
			end
			apb(0, `REG_STATE, 0);
			chk("state", {18'h0, n_e, z_e, k[3:0], w_e}, rd);
		end
		presetn <= 0;
		repeat (2) @(posedge pclk);
		chk("reset wreg", 0, wreg);
		chk("reset bank", 0, bank_select_register);
		chk("reset flags", 0, {flag_n, flag_z});
		presetn <= 1;
		@(posedge pclk);
		apb(0, `REG_CTRL, 0);
		chk("ctrl after reset", 0, rd);
		end_sim;
	end
endmodule : data_move_instruction_exec_test
